// file: lfwt_pkg.sv
// Purpose: Shared constants for the low-frequency wake-up timers and filter.
// Assumes: Core clock of 25 MHz; timers step on a 32 kHz tick.
// Notes:   Times are kept in their own unit and converted to ticks here.
`default_nettype none

package lfwt_pkg;

  // ==========================================================================
  // Clock and tick timing
  // ==========================================================================
  localparam int LFWT_CLK_PERIOD_NS  = 40;     // Core clock period.
  localparam int LFWT_TICK_PERIOD_NS = 31250;  // Nominal 32 kHz tick period.
  localparam int LFWT_NS_PER_MS      = 1000000;
  localparam int LFWT_NS_PER_US      = 1000;
  // Core cycles per oscillator tick, rounded down.
  localparam int LFWT_TICK_CYCLES = LFWT_TICK_PERIOD_NS / LFWT_CLK_PERIOD_NS;
  // Oscillator ticks per millisecond.
  localparam int LFWT_TICKS_PER_MS = LFWT_NS_PER_MS / LFWT_TICK_PERIOD_NS;

  // ==========================================================================
  // Timer periods in microseconds and in ticks
  // ==========================================================================
  localparam int LFWT_INACT_US       = 16000;  // Inactivity timeout.
  localparam int LFWT_ALARM_US       = 32000;  // Noise alarm timeout.
  localparam int LFWT_SETTLE_US      = 3500;   // Gain settle time.
  localparam int LFWT_GAP_US         = 250;    // Post-settle gap.
  localparam int LFWT_RESTART_GAP_US = 500;    // Restart gap after long high.
  localparam int LFWT_INACT_TICKS  =
    LFWT_INACT_US * LFWT_NS_PER_US / LFWT_TICK_PERIOD_NS;
  localparam int LFWT_ALARM_TICKS  =
    LFWT_ALARM_US * LFWT_NS_PER_US / LFWT_TICK_PERIOD_NS;
  localparam int LFWT_SETTLE_TICKS =
    LFWT_SETTLE_US * LFWT_NS_PER_US / LFWT_TICK_PERIOD_NS;
  localparam int LFWT_GAP_TICKS    =
    LFWT_GAP_US * LFWT_NS_PER_US / LFWT_TICK_PERIOD_NS;
  localparam int LFWT_RGAP_TICKS   =
    LFWT_RESTART_GAP_US * LFWT_NS_PER_US / LFWT_TICK_PERIOD_NS;
  localparam int LFWT_SRST_TICKS   = 1;        // Soft reset lasts one tick.

  // ==========================================================================
  // Timer counters
  // ==========================================================================
  localparam int LFWT_TMR_W = 11;              // Holds up to 2047 ticks.
  typedef logic [LFWT_TMR_W-1:0] lfwt_cnt_type;
  localparam int LFWT_NUM_TMR = 5;
  localparam int LFWT_TMR_INACT  = 0;          // Inactivity timer.
  localparam int LFWT_TMR_ALARM  = 1;          // Noise alarm timer.
  localparam int LFWT_TMR_PULSE  = 2;          // Pulse width timer.
  localparam int LFWT_TMR_PERIOD = 3;          // Period timer.
  localparam int LFWT_TMR_SEQ    = 4;          // Settle, gap and reset timer.

  // ==========================================================================
  // Wake filter selector tables in milliseconds
  // ==========================================================================
  localparam logic [1:0] LFWT_SEL_OFF = 2'h0;  // High select: filter off.
  localparam logic [3:0] LFWT_HMIN_MS [0:3] = '{4'h0, 4'h1, 4'h2, 4'h4};
  localparam logic [3:0] LFWT_LMIN_MS [0:3] = '{4'h1, 4'h1, 4'h2, 4'h4};
  // Indexed by {high select, low select}.
  localparam logic [3:0] LFWT_PMAX_MS [0:15] = '{
    4'h0, 4'h0, 4'h0, 4'h0,
    4'h3, 4'h3, 4'h4, 4'h6,
    4'h4, 4'h4, 4'h5, 4'h8,
    4'h6, 4'h6, 4'h8, 4'hA};

  localparam int LFWT_CHANS = 3;               // Receive channels.

  // Front end sequencing states.
  typedef enum logic [3:0] {
    ST_SRST, ST_STBY, ST_SETTLE, ST_GAP, ST_ARM,
    ST_HIGH, ST_LOW, ST_OPEN, ST_RGAP
  } lfwt_state_type;

endpackage

`default_nettype wire

// file: lfwt_timer_if.sv
// Purpose: Control and count of one tick timer.
// Assumes: Driven by the sequencer, served by one tick timer.
// Notes:   Clear has priority over counting.
`timescale 1ns/10ps
`default_nettype none

interface lfwt_timer_if;
  import lfwt_pkg::*;
  logic         clr;  // Restart the count at zero.
  logic         run;  // Count one tick this cycle.
  lfwt_cnt_type cnt;  // Ticks counted since the last clear.

  modport owner (output clr, output run, input cnt);
  modport counter (input clr, input run, output cnt);
endinterface

`default_nettype wire

// file: lfwt_tick_timer.sv
// Purpose: Saturating tick counter for one front end timer.
// Assumes: The run strobe is one core cycle per oscillator tick.
// Notes:   Saturation keeps a long-expired timer from wrapping.
`timescale 1ns/10ps
`default_nettype none

module lfwt_tick_timer
  import lfwt_pkg::*;
(
  input  wire logic          i_clock,
  input  wire logic          i_resetn,
  lfwt_timer_if.counter      tmr
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  lfwt_cnt_type cnt_q;  // Current count.

  // Clear wins, otherwise count ticks and stop at the top value.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= '0;
    end
    else if (tmr.clr)
    begin
      cnt_q <= '0;
    end
    else if (tmr.run && (cnt_q != '1))
    begin
      cnt_q <= cnt_q + lfwt_cnt_type'(1);
    end
  end

  assign tmr.cnt = cnt_q;

endmodule

`default_nettype wire

// file: lfwt_front_end_timers.sv
// Purpose: Wake-up timers and output enable filter of the LF receiver.
// Assumes: Envelope, chip select and channel inputs are asynchronous pins.
// Notes:   A 32 kHz tick is divided from the core clock for all timers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1: All timers step on one 32 kHz tick.
// R2: Sixteen ms without activity issues soft reset.
// R3: Envelope edges, chip select, reset clear inactivity.
// R4: Inactivity counts only after signal is received.
// R5: Unqualified signal for 32 ms raises alarm.
// R6: Alarm timer cleared by select, disable, open.
// R7: Alarm stays idle while filter is disabled.
// R8: Pulse timer checks minimum high and low.
// R9: Period timer checks the maximum period.
// R10: Settle timer holds filter; low aborts.
// R11: Status records channels that finished settling.
// R12: Data blocked until header high-low matches.
// R13: Host programs high selector; zero disables.
// R14: High timed rise to fall, within limits.
// R15: Low timed fall to rise, within limits.
// R16: Rise-to-rise period must not exceed maximum.
// R17: Low code zero bounds low by inactivity.
// R18: Short, long or reset restarts the filter.
// R19: Signal dropout during high resets filter.
// R20: Long high waits gap and new rise.
// R21: Disabled filter passes all received data.
// R22: Qualification starts right after settle gap.
// R23: Soft reset lasts one tick, clamps modulator.
// R24: Millisecond limits are counts of ticks.
module lfwt_front_end_timers
  import lfwt_pkg::*;
#(
  parameter int TICK_CYCLES = LFWT_TICK_CYCLES  // Core cycles per tick.
)
(
  input  wire logic                  i_clock,
  input  wire logic                  i_resetn,
  input  wire logic                  i_envelope,
  input  wire logic                  i_cs_n,
  input  wire logic [LFWT_CHANS-1:0] i_chan_high,
  input  wire logic                  i_soft_reset_cmd,
  input  wire logic [1:0]            i_wake_high_sel,
  input  wire logic [1:0]            i_wake_low_sel,
  output logic                       o_lf_data_out,
  output logic                       o_alert_n,
  output logic                       o_alarm_flag,
  output logic [LFWT_CHANS-1:0]      o_chan_wake,
  output logic                       o_soft_reset,
  output logic                       o_mod_clamp,
  output logic                       o_standby,
  output logic                       o_filter_open
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam int DIV_W = 16;              // Width of the tick divider.
  typedef logic [DIV_W-1:0] lfwt_div_type;

  logic                  env_s1_q;        // Envelope, first sync stage.
  logic                  env_s2_q;        // Envelope, second sync stage.
  logic                  env_prev_q;      // Envelope one cycle earlier.
  logic                  cs_s1_q;         // Chip select, first stage.
  logic                  cs_s2_q;         // Chip select, second stage.
  logic [LFWT_CHANS-1:0] chan_s1_q;       // Channel levels, first stage.
  logic [LFWT_CHANS-1:0] chan_s2_q;       // Channel levels, second stage.
  lfwt_div_type          div_q;           // Tick divider count.
  logic                  tick_q;          // One-cycle 32 kHz tick.
  lfwt_state_type        state_q;         // Sequencer state.
  lfwt_state_type        state_d;         // Next sequencer state.
  logic                  env_rise;        // Envelope went high.
  logic                  env_fall;        // Envelope went low.
  logic                  cs_low;          // An SPI access is in progress.
  logic                  filter_en;       // Wake filter is enabled.
  logic                  active;          // Front end is awake.
  logic                  inact_exp;       // Inactivity timeout reached.
  logic                  alarm_exp;       // Alarm timeout reached.
  logic                  entering;        // State changes this cycle.
  lfwt_cnt_type          high_min_t;      // Minimum high in ticks.
  lfwt_cnt_type          low_min_t;       // Minimum low in ticks.
  lfwt_cnt_type          per_max_t;       // Maximum period in ticks.
  lfwt_cnt_type          low_lim_t;       // Longest allowed low in ticks.
  logic                  alarm_q;         // Sticky noise alarm.
  logic                  alert_n_q;       // Registered active-low alert.
  logic                  data_q;          // Registered data output.
  logic [LFWT_CHANS-1:0] chan_q;          // Channels that woke the front end.
  logic                  srst_q;          // Registered soft reset.
  logic                  stby_q;          // Registered standby.
  logic                  open_q;          // Registered filter open.

  lfwt_timer_if tmr_if [LFWT_NUM_TMR] (); // One link for each timer.

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // The envelope, chip select and channel pins pass two flip-flops; the second stage is read, and env_prev_q adds a third for the envelope edges.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      env_s1_q   <= 1'b0;
      env_s2_q   <= 1'b0;
      env_prev_q <= 1'b0;
      cs_s1_q    <= 1'b1;
      cs_s2_q    <= 1'b1;
      chan_s1_q  <= '0;
      chan_s2_q  <= '0;
    end
    else
    begin
      env_s1_q   <= i_envelope;
      env_s2_q   <= env_s1_q;
      env_prev_q <= env_s2_q;
      cs_s1_q    <= i_cs_n;
      cs_s2_q    <= cs_s1_q;
      chan_s1_q  <= i_chan_high;
      chan_s2_q  <= chan_s1_q;
    end
  end

  assign env_rise = env_s2_q & ~env_prev_q;
  assign env_fall = ~env_s2_q & env_prev_q;
  assign cs_low   = ~cs_s2_q;

  // ==========================================================================
  // Oscillator tick
  // ==========================================================================
  // The divider stands in for the internal RC oscillator.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (div_q >= lfwt_div_type'(TICK_CYCLES - 1))
    begin
      div_q  <= '0;
      tick_q <= 1'b1;  // R1
    end
    else
    begin
      div_q  <= div_q + lfwt_div_type'(1);
      tick_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Filter limits
  // ==========================================================================
  // The selectors index millisecond tables scaled to ticks.
  assign filter_en = (i_wake_high_sel != LFWT_SEL_OFF);  // R13

  always_comb
  begin
    high_min_t = lfwt_cnt_type'(LFWT_HMIN_MS[i_wake_high_sel]
                                * LFWT_TICKS_PER_MS);  // R24
    low_min_t  = lfwt_cnt_type'(LFWT_LMIN_MS[i_wake_low_sel]
                                * LFWT_TICKS_PER_MS);  // R15
    per_max_t  = lfwt_cnt_type'(LFWT_PMAX_MS[{i_wake_high_sel,
                                i_wake_low_sel}] * LFWT_TICKS_PER_MS);  // R16
    // Low code zero lets the low run up to the inactivity timeout.
    if (i_wake_low_sel == LFWT_SEL_OFF)
    begin
      low_lim_t = lfwt_cnt_type'(LFWT_INACT_TICKS);  // R17
    end
    else
    begin
      low_lim_t = per_max_t;
    end
  end

  // ==========================================================================
  // Timers
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < LFWT_NUM_TMR; g++)
    begin : g_tmr
      lfwt_tick_timer u_tmr (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .tmr      (tmr_if[g])
      );
    end
  endgenerate

  assign active   = (state_q != ST_STBY) && (state_q != ST_SRST);
  assign entering = (state_d != state_q);

  // Inactivity runs only once signal has woken the front end.
  assign tmr_if[LFWT_TMR_INACT].run = tick_q & active;  // R4
  assign tmr_if[LFWT_TMR_INACT].clr =
    env_rise | env_fall | cs_low | ~active;  // R3
  assign inact_exp = active && (tmr_if[LFWT_TMR_INACT].cnt
                     >= lfwt_cnt_type'(LFWT_INACT_TICKS));  // R2

  // Alarm counts unqualified signal while the filter is in use.
  assign tmr_if[LFWT_TMR_ALARM].run =
    tick_q & active & filter_en & (state_q != ST_OPEN);  // R7
  assign tmr_if[LFWT_TMR_ALARM].clr =
    cs_low | ~filter_en | (state_q == ST_OPEN) | ~active;  // R6
  assign alarm_exp = filter_en && (tmr_if[LFWT_TMR_ALARM].cnt
                     >= lfwt_cnt_type'(LFWT_ALARM_TICKS));  // R5

  // Pulse width restarts at every accepted edge of the header.
  assign tmr_if[LFWT_TMR_PULSE].run = tick_q;
  assign tmr_if[LFWT_TMR_PULSE].clr =
    entering && ((state_d == ST_HIGH) || (state_d == ST_LOW));  // R8
  // Period restarts only at the rising edge that opens a high.
  assign tmr_if[LFWT_TMR_PERIOD].run = tick_q;
  assign tmr_if[LFWT_TMR_PERIOD].clr =
    entering && (state_d == ST_HIGH);  // R9
  // The sequence timer times each timed state from its entry.
  assign tmr_if[LFWT_TMR_SEQ].run = tick_q;
  assign tmr_if[LFWT_TMR_SEQ].clr = entering;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Walks settle, gap and the high-low header, then opens the output.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_SRST:
      begin
        // One tick of initialisation, then low-current standby.
        if (tmr_if[LFWT_TMR_SEQ].cnt >= lfwt_cnt_type'(LFWT_SRST_TICKS))
        begin
          state_d = ST_STBY;  // R23
        end
      end
      ST_STBY:
      begin
        // Received signal wakes the front end and starts settling.
        if (env_rise)
        begin
          state_d = ST_SETTLE;  // R4
        end
      end
      ST_SETTLE:
      begin
        // Filter held while gain settles; input must still be high.
        if (tmr_if[LFWT_TMR_SEQ].cnt >= lfwt_cnt_type'(LFWT_SETTLE_TICKS))
        begin
          state_d = env_s2_q ? ST_GAP : ST_SRST;  // R10
        end
      end
      ST_GAP:
      begin
        // Qualification begins as soon as the gap ends.
        if (tmr_if[LFWT_TMR_SEQ].cnt >= lfwt_cnt_type'(LFWT_GAP_TICKS))
        begin
          state_d = filter_en ? ST_ARM : ST_OPEN;  // R22
        end
      end
      ST_ARM:
      begin
        // Wait for the rising edge that starts a fresh high.
        if (!filter_en)
        begin
          state_d = ST_OPEN;  // R21
        end
        else if (env_rise)
        begin
          state_d = ST_HIGH;  // R14
        end
      end
      ST_HIGH:
      begin
        if (!filter_en)
        begin
          state_d = ST_OPEN;  // R21
        end
        else if (tmr_if[LFWT_TMR_PULSE].cnt > per_max_t)
        begin
          state_d = ST_RGAP;  // R20
        end
        else if (env_fall)
        begin
          // A drop before the minimum high counts as a loss of signal.
          if (tmr_if[LFWT_TMR_PULSE].cnt >= high_min_t)
          begin
            state_d = ST_LOW;  // R14
          end
          else
          begin
            state_d = ST_ARM;  // R19
          end
        end
      end
      ST_LOW:
      begin
        if (!filter_en)
        begin
          state_d = ST_OPEN;  // R21
        end
        else if ((tmr_if[LFWT_TMR_PULSE].cnt > low_lim_t) ||
                 ((i_wake_low_sel != LFWT_SEL_OFF) &&
                  (tmr_if[LFWT_TMR_PERIOD].cnt > per_max_t)))
        begin
          state_d = ST_ARM;  // R18
        end
        else if (env_rise)
        begin
          // The header matches; otherwise this rise starts a new high.
          if ((tmr_if[LFWT_TMR_PULSE].cnt >= low_min_t) &&
              ((i_wake_low_sel == LFWT_SEL_OFF) ||
               (tmr_if[LFWT_TMR_PERIOD].cnt <= per_max_t)))
          begin
            state_d = ST_OPEN;  // R12
          end
          else
          begin
            state_d = ST_HIGH;  // R18
          end
        end
      end
      ST_RGAP:
      begin
        // After an overlong high, wait the gap, then a new rise.
        if (tmr_if[LFWT_TMR_SEQ].cnt >= lfwt_cnt_type'(LFWT_RGAP_TICKS))
        begin
          state_d = ST_ARM;  // R20
        end
      end
      ST_OPEN:
      begin
        // Data passes until the next soft reset.
        state_d = ST_OPEN;
      end
      default:
      begin
        state_d = ST_SRST;
      end
    endcase
    // A soft reset from any awake state beats every other move.
    if (active && (i_soft_reset_cmd || inact_exp))
    begin
      state_d = ST_SRST;  // R18
    end
  end

  // State register; power-up begins with a soft reset.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= ST_SRST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Status and outputs
  // ==========================================================================
  // Alarm is sticky; a new timeout wins over a clear by chip select.
  // The alert pin has its own flop so that it leaves a register directly.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      alarm_q   <= 1'b0;
      alert_n_q <= 1'b1;
    end
    else if (alarm_exp)
    begin
      alarm_q   <= 1'b1;  // R5
      alert_n_q <= 1'b0;  // R5
    end
    else if (cs_low)
    begin
      alarm_q   <= 1'b0;  // R6
      alert_n_q <= 1'b1;
    end
  end

  // Channels high at the end of settling are recorded together.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      chan_q <= '0;
    end
    else if ((state_q == ST_SETTLE) && (state_d == ST_GAP))
    begin
      chan_q <= chan_s2_q;  // R11
    end
    else if ((state_q == ST_STBY) && (state_d == ST_SETTLE))
    begin
      chan_q <= '0;
    end
  end

  // Data stays blocked until the header qualifies or the filter is off.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      data_q <= 1'b0;
    end
    else if ((state_d == ST_OPEN) || (active && !filter_en))
    begin
      data_q <= env_s2_q;  // R21
    end
    else
    begin
      data_q <= 1'b0;  // R12
    end
  end

  // Mode outputs follow the next state so they line up with it.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      srst_q <= 1'b1;
      stby_q <= 1'b0;
      open_q <= 1'b0;
    end
    else
    begin
      srst_q <= (state_d == ST_SRST);  // R23
      stby_q <= (state_d == ST_STBY);
      open_q <= (state_d == ST_OPEN);
    end
  end

  assign o_lf_data_out = data_q;
  assign o_alert_n     = alert_n_q;
  assign o_alarm_flag  = alarm_q;
  assign o_chan_wake   = chan_q;
  assign o_soft_reset  = srst_q;
  assign o_mod_clamp   = srst_q;
  assign o_standby     = stby_q;
  assign o_filter_open = open_q;

endmodule

`default_nettype wire

// file: lfwt_asserts.sv
// Purpose: Port level checks of the wake timers and filter.
// Assumes: One tick lasts TICK_CYCLES core cycles.
// Notes:   Bound into every instance of the timer block.
`timescale 1ns/10ps
`default_nettype none
module lfwt_asserts
  import lfwt_pkg::*;
#(
  parameter int TICK_CYCLES = 4  // Core cycles per tick.
)
(
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_envelope,
  input  wire logic       i_cs_n,
  input  wire logic       i_soft_reset_cmd,
  input  wire logic [1:0] i_wake_high_sel,
  input  wire logic       o_lf_data_out,
  input  wire logic       o_alert_n,
  input  wire logic       o_alarm_flag,
  input  wire logic       o_soft_reset,
  input  wire logic       o_mod_clamp,
  input  wire logic       o_standby,
  input  wire logic       o_filter_open
);
  int srst_q;  // Cycles that the soft reset has stood.
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Counts the length of each soft reset.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      srst_q <= 0;
    else
      srst_q <= o_soft_reset ? srst_q + 1 : 0;
  end
  chk_reset_short: assert property (srst_q <= 2 * TICK_CYCLES + 2)
    else $error("soft reset too long");
  chk_clamp_follows: assert property (o_mod_clamp == o_soft_reset)
    else $error("clamp differs from soft reset");
  chk_alert_mirror: assert property (o_alert_n == !o_alarm_flag)
    else $error("alert pin differs from alarm flag");
  chk_standby_entry: assert property ($fell(o_soft_reset) |-> o_standby)
    else $error("soft reset did not end in standby");
  chk_cmd_taken: assert property (i_soft_reset_cmd && !o_standby
    && !o_soft_reset |=> o_soft_reset) else $error("command ignored");
  chk_wake_leave: assert property ($rose(i_envelope) && o_standby
    |-> ##[1:6] !o_standby) else $error("no wake on signal");
  chk_alarm_idle: assert property ($rose(o_alarm_flag)
    |-> $past(i_wake_high_sel) != LFWT_SEL_OFF) else $error("alarm off");
  chk_alarm_clear: assert property ($fell(o_alarm_flag) |->
    !$past(i_cs_n, 2) || !$past(i_cs_n, 3) || !$past(i_cs_n, 4))
    else $error("alarm cleared without select");
  chk_data_gate: assert property (o_lf_data_out |-> o_filter_open
    || $past(o_filter_open) || $past(i_wake_high_sel) == LFWT_SEL_OFF)
    else $error("data passed before qualification");
endmodule
bind lfwt_front_end_timers lfwt_asserts #(.TICK_CYCLES(TICK_CYCLES))
  i_lfwt_asserts (.i_clock, .i_resetn, .i_envelope, .i_cs_n,
  .i_soft_reset_cmd, .i_wake_high_sel, .o_lf_data_out, .o_alert_n,
  .o_alarm_flag, .o_soft_reset, .o_mod_clamp, .o_standby, .o_filter_open);
`default_nettype wire

// file: lfwt_host_model.sv
// Purpose: Host model that programs the selectors and watches alerts.
// Assumes: A command request lasts one cycle.
// Notes:   Chip select stays low four cycles for each command.
`timescale 1ns/10ps
`default_nettype none
module lfwt_host_model
(
  input  wire logic       i_clock,
  input  wire logic       i_cmd,
  input  wire logic [1:0] i_hsel,
  input  wire logic [1:0] i_lsel,
  input  wire logic       i_alert_n,
  output logic            o_cs_n,
  output logic [1:0]      o_hsel,
  output logic [1:0]      o_lsel,
  output logic            o_alert_seen
);
  int n = 0;  // Chip select cycles still to run.
  initial {o_cs_n, o_hsel, o_lsel} = 5'h10;
  // A command pulls select low, then loads the new selectors.
  always @(negedge i_clock)
  begin
    if (i_cmd) n = 4;
    o_cs_n = (n == 0);
    if (n == 1) {o_hsel, o_lsel} = {i_hsel, i_lsel};
    if (n > 0) n = n - 1;
  end
  assign o_alert_seen = !i_alert_n;  // The alert pin is active low.
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the wake timers and filter.
// Assumes: Ticks shortened to four core cycles.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int TC = 4;  // Core cycles per tick.
  logic clk = 0, rstn = 0, env = 0, cmd = 0, hcmd = 0;
  logic [2:0] chan = 0, cw;  // Channel levels and wake status.
  logic [1:0] hh = 0, hl = 0, hs, ls;
  logic cs_n, data, alert_n, alarm, srst, clamp, stby, open, seen;
  int n_mismatch = 0, comparisons = 0;
  lfwt_front_end_timers #(.TICK_CYCLES(TC)) i_lfwt_front_end_timers (
    .i_clock(clk), .i_resetn(rstn), .i_envelope(env), .i_cs_n(cs_n),
    .i_chan_high(chan), .i_soft_reset_cmd(cmd), .i_wake_high_sel(hs),
    .i_wake_low_sel(ls), .o_lf_data_out(data), .o_alert_n(alert_n),
    .o_alarm_flag(alarm), .o_chan_wake(cw), .o_soft_reset(srst),
    .o_mod_clamp(clamp), .o_standby(stby), .o_filter_open(open));
  lfwt_host_model i_lfwt_host_model (.i_clock(clk), .i_cmd(hcmd),
    .i_hsel(hh), .i_lsel(hl), .i_alert_n(alert_n), .o_cs_n(cs_n),
    .o_hsel(hs), .o_lsel(ls), .o_alert_seen(seen));
  initial forever #20 clk = ~clk;
  task automatic check(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %b", $time, got);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n * TC) @(negedge clk);
  endtask
  task automatic set_sel(input logic [1:0] h, input logic [1:0] l);
    {hh, hl, hcmd} <= {h, l, 1'b1};
    @(negedge clk) hcmd <= 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // Drops the envelope, lets the low be seen, then waits for standby.
  task automatic idle();
    env = 0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 3000 && stby !== 1'b1; i++) @(negedge clk);
    if (stby !== 1'b1)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  // Holds the envelope through settling and the gap.
  task automatic wake();
    env = 1;
    ticks(124);
    check(stby, 1'b0);
    env = 0;
    ticks(2);
  endtask
  task automatic pulse(input int h, input int l);
    env = 1;
    ticks(h);
    env = 0;
    ticks(l);
  endtask
  // A short high is refused, a good header opens, idling ends it.
  task automatic s_qualify();
    set_sel(2'h1, 2'h1);
    idle();
    chan = 3'h5;
    wake();
    chan = 3'h0;
    check(cw == 3'h5, 1'b1);
    pulse(10, 40);
    env = 1;
    ticks(38);
    check(open, 1'b0);
    check(data, 1'b0);
    env = 0;
    ticks(40);
    env = 1;
    ticks(2);
    check(open, 1'b1);
    check(data, 1'b1);
    ticks(400);
    set_sel(2'h1, 2'h1);
    ticks(500);
    check(stby, 1'b0);
    ticks(30);
    check(stby, 1'b1);
  endtask
  // Period over the maximum, long high and gap, low code zero, abort.
  task automatic s_period_abort();
    idle();
    wake();
    pulse(40, 60);
    env = 1;
    ticks(2);
    check(open, 1'b0);
    ticks(100);
    env = 0;
    ticks(2);
    pulse(40, 40);
    env = 1;
    ticks(2);
    check(open, 1'b0);
    set_sel(2'h1, 2'h0);
    pulse(38, 100);
    env = 1;
    ticks(2);
    check(open, 1'b1);
    idle();
    env = 1;
    ticks(50);
    env = 0;
    ticks(70);
    check(stby, 1'b1);
  endtask
  // Noise raises the alarm, select clears it, filter off passes data.
  task automatic s_alarm();
    idle();
    wake();
    repeat (110) pulse(5, 5);
    check(alarm, 1'b1);
    check(seen, 1'b1);
    set_sel(2'h1, 2'h1);
    check(alarm, 1'b0);
    set_sel(2'h0, 2'h0);
    idle();
    wake();
    repeat (110) pulse(5, 5);
    check(alarm, 1'b0);
    env = 1;
    ticks(1);
    check(data, 1'b1);
    cmd = 1;
    @(negedge clk) cmd = 0;
    @(negedge clk);
    check(srst, 1'b1);
    check(clamp, 1'b1);
    ticks(3);
    check(stby, 1'b1);
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    check(srst, 1'b1);
    check(alert_n, 1'b1);
    rstn = 1;
    s_qualify();
    s_period_abort();
    s_alarm();
    summarize();
  end
endmodule
`default_nettype wire
